/* verilog/dma_full_consts.svh */
`ifndef DMA_FULL_CONSTS_SVH
`define DMA_FULL_CONSTS_SVH

// Register byte offsets
`define OFS_SOURCE_ADDRESS_A      8'h00
`define OFS_DESTINATION_ADDRESS_B 8'h04
`define OFS_TRANSFER_COUNT_A      8'h08
`define OFS_BLOCK_COUNT           8'h0C
`define OFS_CHANNEL_CONTROL       8'h10
`define OFS_STATUS                8'h14

// Control register fields
`define CTL_CHANNEL_ENABLE        0
`define CTL_FULL_ADDRESS_ENABLE   1
`define CTL_BLOCK_ENABLE          2
`define CTL_END_IRQ_ENABLE        3
`define CTL_TRANSFER_SIZE         4
`define CTL_SOURCE_STEP_ENABLE    5
`define CTL_SOURCE_STEP_DIR       6
`define CTL_DEST_STEP_ENABLE      7
`define CTL_DEST_STEP_DIR         8
`define CTL_BLOCK_AREA_SELECT     9
`define CTL_BURST                 10
`define CTL_SRC_LSB               11
`define CTL_SRC_MSB               14
`define CTL_SINGLE_ADDRESS        15
`define CTL_CHANNEL_B             16
`define CTL_WIDTH                 17
`define CTL_RESET                 17'h00000

// Status register fields
`define STA_BUSY                  0
`define STA_DONE                  1
`define STA_EDGE_PENDING          2

// Activation source codes
`define SRC_AUTO                  4'h0
`define SRC_EXT_EDGE              4'h1
`define SRC_EXT_LEVEL             4'h2
`define SRC_INT_FIRST             4'h3
`define SRC_INT_LAST              4'hD

// Address steps and counter values
`define STEP_BYTE                 24'h000001
`define STEP_WORD                 24'h000002
`define COUNT_ONE16               16'h0001
`define COUNT_ONE8                8'h01

// AXI responses
`define RESP_OKAY                 2'h0
`define RESP_SLVERR               2'h2

`endif

/* verilog/dma_full_pkg.sv */
package dma_full_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_XFER = 2'b10
  } engine_state_t;
endpackage

/* verilog/ext_request_sense.sv */
`timescale 1ns/1ps
`default_nettype none
module ext_request_sense (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic ext_transfer_request_pin_n,
  output logic      request_low,
  output logic      request_fall
);
  logic sync_first;
  logic sync_second;
  logic sync_prev;

  // Two stages before any logic; pin idles high
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_first  <= 1'b1;
      sync_second <= 1'b1;
      sync_prev   <= 1'b1;
    end else begin
      sync_first  <= ext_transfer_request_pin_n;
      sync_second <= sync_first;
      sync_prev   <= sync_second;
    end
  end

  assign request_low  = ~sync_second;
  assign request_fall = sync_prev & ~sync_second;
endmodule
`default_nettype wire

/* verilog/dma_full_address_block_xfer.sv */
// Local design decisions: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "dma_full_consts.svh"

module dma_full_address_block_xfer #(
  parameter int NUM_IRQ = 11
) (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic [7:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [7:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  input  wire logic [NUM_IRQ-1:0] peripheral_irq,
  input  wire logic               ext_transfer_request_pin_n,
  output logic                    xfer_req,
  output logic [23:0]             xfer_src_addr,
  output logic [23:0]             xfer_dst_addr,
  output logic                    xfer_word,
  output logic                    xfer_single,
  input  wire logic               xfer_ack,
  output logic                    bus_hold,
  output logic                    ext_device_ack_strobe_n,
  output logic                    end_irq_req
);

  ////////////////////////////////////////////////////////////////////////////
  logic [23:0]              source_address_a;
  logic [23:0]              destination_address_b;
  logic [15:0]              transfer_count_a;
  logic [15:0]              block_count;
  logic [`CTL_WIDTH-1:0]    channel_control_reg;
  logic                     done_flag;
  logic [23:0]              block_start;
  logic                     edge_pending;
  logic                     irq_pending;
  logic                     burst_active;
  dma_full_pkg::engine_state_t state;

  logic                     request_low;
  logic                     request_fall;
  logic                     aw_got;
  logic                     w_got;
  logic [7:0]               aw_addr;
  logic [31:0]              w_data;
  logic [3:0]               w_strb;
  logic                     commit;

  logic                     channel_enable_bit;
  logic                     full_address_enable;
  logic                     block_enable_bit;
  logic                     block_area_select;
  logic [3:0]               src_sel;
  logic                     src_auto;
  logic                     src_ext;
  logic                     src_int;
  logic                     normal_mode;
  logic                     block_mode;
  logic                     allowed;
  logic                     int_level;
  logic                     trigger;
  logic [23:0]              next_source;
  logic [23:0]              next_dest;
  logic                     size_last;
  logic                     normal_last;
  logic                     block_last;
  logic                     xfer_end;
  logic                     keep_bus;

  ext_request_sense u_sense (
    .aclk                       (aclk),
    .aresetn                    (aresetn),
    .ext_transfer_request_pin_n (ext_transfer_request_pin_n),
    .request_low                (request_low),
    .request_fall               (request_fall)
  );

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = val[8*i +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [23:0] stepped(input logic [23:0] addr, input logic en, input logic down,
                                          input logic word);
    logic [23:0] step;
    step = word ? `STEP_WORD : `STEP_BYTE;
    if (!en) begin
      return addr;
    end
    return down ? addr - step : addr + step;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Mode and source decode
  assign channel_enable_bit  = channel_control_reg[`CTL_CHANNEL_ENABLE];
  assign full_address_enable = channel_control_reg[`CTL_FULL_ADDRESS_ENABLE];
  assign block_enable_bit    = channel_control_reg[`CTL_BLOCK_ENABLE];
  assign block_area_select   = channel_control_reg[`CTL_BLOCK_AREA_SELECT];
  assign src_sel             = channel_control_reg[`CTL_SRC_MSB:`CTL_SRC_LSB];
  assign normal_mode = full_address_enable & ~block_enable_bit;
  assign block_mode  = full_address_enable & block_enable_bit;
  assign src_auto    = (src_sel == `SRC_AUTO);
  assign src_ext     = (src_sel == `SRC_EXT_EDGE) | (src_sel == `SRC_EXT_LEVEL);
  assign src_int     = (src_sel >= `SRC_INT_FIRST) & (src_sel <= `SRC_INT_LAST);
  assign allowed = (src_auto & normal_mode)
                 | (src_ext & (full_address_enable | channel_control_reg[`CTL_CHANNEL_B]))
                 | (src_int & ~normal_mode);
  assign int_level = src_int & peripheral_irq[src_sel - `SRC_INT_FIRST];
  // level keeps requesting, edge consumes a pending flag
  assign trigger = channel_enable_bit & allowed
                 & (src_auto | (src_sel == `SRC_EXT_LEVEL && request_low) | edge_pending | irq_pending);

  ////////////////////////////////////////////////////////////////////////////
  // Counters and address stepping at the end of each transfer
  // independent step per register
  assign next_source = stepped(source_address_a, channel_control_reg[`CTL_SOURCE_STEP_ENABLE],
                               channel_control_reg[`CTL_SOURCE_STEP_DIR], xfer_word);
  assign next_dest   = stepped(destination_address_b, channel_control_reg[`CTL_DEST_STEP_ENABLE],
                               channel_control_reg[`CTL_DEST_STEP_DIR], xfer_word);
  // zero wraps to FFFF and so runs 65,536 times
  assign normal_last = (transfer_count_a == `COUNT_ONE16);
  assign size_last   = (transfer_count_a[7:0] == `COUNT_ONE8);
  assign block_last  = size_last & (block_count == `COUNT_ONE16);
  assign xfer_end    = block_mode ? block_last : normal_last;
  // bus kept inside a block or an auto burst
  assign keep_bus = channel_enable_bit & ~xfer_end
                  & (block_mode ? ~size_last : (src_auto & channel_control_reg[`CTL_BURST]));

  ////////////////////////////////////////////////////////////////////////////
  // Register bus write side
  assign commit = aw_got & w_got & ~s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      aw_got        <= 1'b0;
      aw_addr       <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_got        <= 1'b1;
      aw_addr       <= s_axi_awaddr;
    end else if (commit) begin
      aw_got        <= 1'b0;
    end else if (!aw_got && !s_axi_bvalid) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b0;
      w_got        <= 1'b0;
      w_data       <= 32'h00000000;
      w_strb       <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_got        <= 1'b1;
      w_data       <= s_axi_wdata;
      w_strb       <= s_axi_wstrb;
    end else if (commit) begin
      w_got        <= 1'b0;
    end else if (!w_got && !s_axi_bvalid) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else if (commit) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (aw_addr > `OFS_STATUS || aw_addr[1:0] != 2'h0) ? `RESP_SLVERR : `RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers: software write wins over hardware update in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      source_address_a      <= 24'h000000;
      destination_address_b <= 24'h000000;
      transfer_count_a      <= 16'h0000;
      block_count           <= 16'h0000;
      channel_control_reg   <= `CTL_RESET;
    end else if (commit && aw_addr == `OFS_SOURCE_ADDRESS_A) begin
      source_address_a <= 24'(merge({8'h00, source_address_a}, w_data, w_strb));
    end else if (commit && aw_addr == `OFS_DESTINATION_ADDRESS_B) begin
      destination_address_b <= 24'(merge({8'h00, destination_address_b}, w_data, w_strb));
    end else if (commit && aw_addr == `OFS_TRANSFER_COUNT_A) begin
      transfer_count_a <= 16'(merge({16'h0000, transfer_count_a}, w_data, w_strb));
    end else if (commit && aw_addr == `OFS_BLOCK_COUNT) begin
      block_count <= 16'(merge({16'h0000, block_count}, w_data, w_strb));
    end else if (commit && aw_addr == `OFS_CHANNEL_CONTROL) begin
      channel_control_reg <= `CTL_WIDTH'(merge({15'h0000, channel_control_reg}, w_data, w_strb));
    end else if (state == dma_full_pkg::ST_XFER && xfer_ack) begin
      source_address_a      <= next_source;
      destination_address_b <= next_dest;
      if (block_mode) begin
        // size counter reload from hold byte
        transfer_count_a[7:0] <= size_last ? transfer_count_a[15:8] : transfer_count_a[7:0] - 8'h01;
        if (size_last) begin
          block_count <= block_count - 16'h0001;
          if (block_area_select) begin
            source_address_a <= block_start;
          end else begin
            destination_address_b <= block_start;
          end
        end
      end else begin
        transfer_count_a <= transfer_count_a - 16'h0001;
      end
      if (xfer_end) begin
        channel_control_reg[`CTL_CHANNEL_ENABLE] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request latches; a new pin edge wins over the clear when a transfer starts, a new interrupt level does not
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      edge_pending <= 1'b0;
      irq_pending  <= 1'b0;
    end else begin
      if (!channel_enable_bit) begin
        edge_pending <= 1'b0;
      end else if (request_fall && src_sel == `SRC_EXT_EDGE) begin
        edge_pending <= 1'b1;
      end else if (state == dma_full_pkg::ST_IDLE && trigger) begin
        edge_pending <= 1'b0;
      end
      if (!channel_enable_bit) begin
        irq_pending <= 1'b0;
      end else if (int_level && state == dma_full_pkg::ST_XFER) begin
        irq_pending <= 1'b1;
      end else if (state == dma_full_pkg::ST_IDLE && trigger) begin
        irq_pending <= 1'b0;
      end else if (int_level) begin
        irq_pending <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transfer engine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state                   <= dma_full_pkg::ST_IDLE;
      xfer_req                <= 1'b0;
      xfer_word               <= 1'b0;
      xfer_single             <= 1'b0;
      bus_hold                <= 1'b0;
      burst_active            <= 1'b0;
      ext_device_ack_strobe_n <= 1'b1;
      block_start             <= 24'h000000;
    end else begin
      unique case (state)
        dma_full_pkg::ST_IDLE: begin
          if (trigger) begin
            state        <= dma_full_pkg::ST_XFER;
            xfer_req     <= 1'b1;
            bus_hold     <= 1'b1;
            xfer_word    <= channel_control_reg[`CTL_TRANSFER_SIZE];
            xfer_single  <= channel_control_reg[`CTL_SINGLE_ADDRESS];
            burst_active <= block_mode;
            ext_device_ack_strobe_n <= ~channel_control_reg[`CTL_SINGLE_ADDRESS];
            if (block_mode && !burst_active) begin
              block_start <= block_area_select ? source_address_a : destination_address_b;
            end
          end
        end
        dma_full_pkg::ST_XFER: begin
          // a stop only takes effect once the transfer is acknowledged
          if (xfer_ack) begin
            // burst continues without a new request
            if (keep_bus) begin
              xfer_req <= 1'b1;
            end else begin
              state                   <= dma_full_pkg::ST_IDLE;
              xfer_req                <= 1'b0;
              bus_hold                <= 1'b0;
              burst_active            <= 1'b0;
              ext_device_ack_strobe_n <= 1'b1;
            end
          end
        end
      endcase
    end
  end

  assign xfer_src_addr = source_address_a;
  assign xfer_dst_addr = destination_address_b;

  // End request pulse; done flag set beats a software clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      end_irq_req <= 1'b0;
      done_flag   <= 1'b0;
    end else begin
      end_irq_req <= state == dma_full_pkg::ST_XFER && xfer_ack && xfer_end
                     && channel_control_reg[`CTL_END_IRQ_ENABLE];
      if (state == dma_full_pkg::ST_XFER && xfer_ack && xfer_end) begin
        done_flag <= 1'b1;
      end else if (commit && aw_addr == `OFS_STATUS && w_strb[0] && w_data[`STA_DONE]) begin
        done_flag <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register bus read side
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= `RESP_OKAY;
      unique case (s_axi_araddr)
        `OFS_SOURCE_ADDRESS_A:      s_axi_rdata <= {8'h00, source_address_a};
        `OFS_DESTINATION_ADDRESS_B: s_axi_rdata <= {8'h00, destination_address_b};
        `OFS_TRANSFER_COUNT_A:      s_axi_rdata <= {16'h0000, transfer_count_a};
        `OFS_BLOCK_COUNT:           s_axi_rdata <= {16'h0000, block_count};
        `OFS_CHANNEL_CONTROL:       s_axi_rdata <= {15'h0000, channel_control_reg};
        `OFS_STATUS:                s_axi_rdata <= {29'h00000000, edge_pending, done_flag,
                                                    state == dma_full_pkg::ST_XFER};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic acked;
  assign acked = state == dma_full_pkg::ST_XFER && xfer_ack && !(commit && aw_addr != `OFS_STATUS);

  chk_normal_end: assert property (acked && normal_mode && normal_last |=> !channel_enable_bit)
    else $error("normal mode did not stop at count one");
  chk_zero_wrap: assert property (acked && normal_mode && transfer_count_a == 16'h0000
    |=> transfer_count_a == 16'hFFFF && channel_enable_bit)
    else $error("zero count did not run on");
  chk_normal_source: assert property (state == dma_full_pkg::ST_IDLE && normal_mode && src_int
    |=> state == dma_full_pkg::ST_IDLE)
    else $error("internal source started normal mode");
  chk_block_no_auto: assert property (state == dma_full_pkg::ST_IDLE && block_mode && src_auto
    |=> !xfer_req)
    else $error("auto request started block mode");
  chk_size_reload: assert property (acked && block_mode && size_last
    |=> transfer_count_a[7:0] == $past(transfer_count_a[15:8]))
    else $error("size counter not reloaded");
  chk_area_restore: assert property (acked && block_mode && size_last && !block_area_select
    |=> destination_address_b == $past(block_start))
    else $error("block area not restored");
  chk_block_end: assert property (acked && block_mode && block_last
    |=> !channel_enable_bit ##0 done_flag)
    else $error("block count end missed");
  chk_steal_release: assert property (acked && !keep_bus |=> !bus_hold && state == dma_full_pkg::ST_IDLE)
    else $error("bus kept after cycle steal transfer");
  chk_single_strobe: assert property (xfer_req |-> ext_device_ack_strobe_n == !xfer_single)
    else $error("strobe does not follow single address mode");
  chk_stop_waits: assert property (state == dma_full_pkg::ST_XFER && !xfer_ack
    |=> state == dma_full_pkg::ST_XFER)
    else $error("transfer abandoned before acknowledge");
endmodule
`default_nettype wire

/* test/bus_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
module bus_ctrl_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       xfer_req,
  input  wire logic [1:0] lat,
  output logic            xfer_ack
);
  logic [1:0] wait_cnt;
  // Ack is one pulse per request, after a varying wait, never early
  always_ff @(posedge aclk) begin
    if (!aresetn || xfer_ack || !xfer_req) begin
      xfer_ack <= 1'b0;
      wait_cnt <= 2'h0;
    end else if (wait_cnt >= lat) begin
      xfer_ack <= 1'b1;
    end else begin
      wait_cnt <= wait_cnt + 2'h1;
    end
  end
endmodule
`default_nettype wire

/* test/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
  logic        bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, xfer_req, xfer_ack, end_irq_req;
  logic        pin_n = 1'b1, word, single, strobe_n, hold;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h00000000, rdata, rv;
  integer      seed = 32'h0000005D;
  logic [1:0]  bresp, rresp, rr, br, lat = 2'h0;
  logic [23:0] src_addr, dst_addr, s, d;
  logic [10:0] irq = 11'h000;
  logic [51:0] q[$];
  int          fail_count = 0, check_count = 0, irq_seen = 0, i;
  always #2 aclk = ~aclk;
  always @(posedge aclk) lat <= 2'($random(seed));
  dma_full_address_block_xfer u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .peripheral_irq(irq), .ext_transfer_request_pin_n(pin_n), .xfer_req(xfer_req),
    .xfer_src_addr(src_addr), .xfer_dst_addr(dst_addr), .xfer_word(word), .xfer_single(single),
    .xfer_ack(xfer_ack), .bus_hold(hold), .ext_device_ack_strobe_n(strobe_n), .end_irq_req(end_irq_req));
  bus_ctrl_model u_bus (.aclk(aclk), .aresetn(aresetn), .xfer_req(xfer_req), .lat(lat), .xfer_ack(xfer_ack));
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (aw && awready) begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
    end while (aw || w || !bvalid);
    br = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    logic ar;
    ar = 1'b1;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (ar && arready) begin
        ar = 1'b0;
        arvalid <= 1'b0;
      end
    end while (!rvalid);
    v = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  // A transfer with no note queued means a request was wrongly honoured
  always @(posedge aclk) begin
    if (aresetn && xfer_req && xfer_ack) begin
      if (q.size() == 0) begin
        chk(64'h1, 64'h0);
      end else begin
        chk({hold, strobe_n, single, word, src_addr, dst_addr}, q.pop_front());
      end
    end
    if (end_irq_req) irq_seen++;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    finish_test;
  end
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    s = 24'($random(seed));
    d = 24'($random(seed));
    wr(8'h00, {8'h00, s});
    wr(8'h04, {8'h00, d});
    wr(8'h08, 32'h00000003);
    for (i = 0; i < 3; i++) q.push_back({4'hD, s + 24'(2 * i), d - 24'(2 * i)});
    wr(8'h10, 32'h000005BB);
    wait (q.size() == 0);
    repeat (4) @(posedge aclk);
    rd(8'h10, rv, rr);
    chk(rv, 32'h000005BA);
    chk(irq_seen, 1);
    wr(8'h00, {8'h00, s});
    wr(8'h04, {8'h00, d});
    wr(8'h08, 32'h00000202);
    chk(br, 2'h0);
    wr(8'h0C, 32'h00000002);
    irq <= 11'h001;
    wr(8'h10, 32'h00001803);
    wr(8'h10, 32'h000000A7);
    repeat (20) @(posedge aclk);
    for (i = 0; i < 4; i++) q.push_back({4'hC, s + 24'(i), d + 24'(i % 2)});
    wr(8'h10, 32'h000018A7);
    wait (q.size() == 0);
    repeat (4) @(posedge aclk);
    irq <= 11'h000;
    rd(8'h04, rv, rr);
    chk(rv, {8'h00, d});
    rd(8'h0C, rv, rr);
    chk(rv, 32'h00000000);
    rd(8'h10, rv, rr);
    chk(rv, 32'h000018A6);
    chk(irq_seen, 1);
    // Pin edges in single address mode; count zero runs on; third edge while disabled
    wr(8'h00, {8'h00, s});
    wr(8'h04, {8'h00, d});
    wr(8'h08, 32'h00000000);
    q.push_back({4'hA, s, d});
    q.push_back({4'hA, s + 24'h000001, d});
    wr(8'h10, 32'h00008823);
    for (i = 0; i < 3; i++) begin
      if (i == 2) begin
        wr(8'h10, 32'h00008822);
      end
      pin_n <= 1'b0;
      repeat (3) @(posedge aclk);
      pin_n <= 1'b1;
      repeat (16) @(posedge aclk);
    end
    rd(8'h08, rv, rr);
    chk(rv, 32'h0000FFFE);
    rd(8'h10, rv, rr);
    chk(rv, 32'h00008822);
    rd(8'h14, rv, rr);
    chk(rv, 32'h00000002);
    wr(8'h40, 32'hFFFFFFFF);
    chk(br, 2'h2);
    rd(8'h40, rv, rr);
    chk(rr, 2'h2);
    finish_test;
  end
endmodule
`default_nettype wire
